// *** verilog/cdm_port.sv ***
// core data memory port with a wishbone register front end
// Functional notes
// - drive 32-bit address of each data access
// - core drives write data when direction high
// - watchpoint at request end halts, enters debug
// - lock high across whole locked sequence
// - size code word 10, half 01, byte 00
// - burst flag high when sequential access follows
// - request low announces access next cycle
// - five-bit mode code valid with address
// - direction low read, high write, announced
// - speculative hint low flags address maybe needed
// - hint never together with request
// - privilege low user, high supervisor
// - sequential flag high when continuing previous address
// - outputs change and inputs sampled at rising edge
// - asynchronous active-low reset restarts known state
`timescale 1ns/10ps
module cdm_port (
  // clock, resets and wait-state enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic core_reset_low,
  input wire logic wait_state_enable,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // data memory interface
  output logic [31:0] loadStoreAddress,
  output logic [31:0] writeData,
  input wire logic [31:0] readData,
  input wire logic accessFaultInput,
  input wire logic watchpointHaltInput,
  output logic busLockHold,
  output logic [1:0] accessSizeCode,
  output logic burstContinueFlag,
  output logic requestLow,
  output logic [4:0] accessModeCode,
  output logic directionSelect,
  output logic speculativeHintLow,
  output logic privilegeLevelSelect,
  output logic sequentialAccessFlag
);
  import cdm_pkg::*;

  // merge a write into a register under the byte enables
  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = wr[8*i +: 8];
      end
    end
    return res;
  endfunction : byteMerge

  // address step for one access of the given size
  function automatic logic [31:0] sizeStep(input logic [1:0] size);
    logic [31:0] step;
    case (size)
      CDM_SIZE_BYTE: step = 32'h0000_0001;
      CDM_SIZE_HALF: step = 32'h0000_0002;
      default: step = 32'h0000_0004;
    endcase
    return step;
  endfunction : sizeStep

  logic portRstLow;
  logic ackQ;
  logic [31:0] datOQ;
  logic [31:0] addrRegQ;
  logic [31:0] wdataRegQ;
  logic [31:0] ctrlRegQ;
  cdm_state_t stateQ;
  cdm_state_t stateD;
  logic [3:0] remQ;
  logic [3:0] remD;
  logic [31:0] curAddrQ;
  logic [31:0] curAddrD;
  logic [31:0] addrOutQ;
  logic [31:0] addrOutD;
  logic [31:0] wdataOutQ;
  logic [4:0] modeOutQ;
  logic reqLowQ;
  logic reqLowD;
  logic seqQ;
  logic seqD;
  logic moreQ;
  logic moreD;
  logic lockQ;
  logic lockD;
  logic specLowQ;
  logic specLowD;
  logic dirQ;
  logic [1:0] sizeQ;
  logic privQ;
  logic abortSeenQ;
  logic haltedQ;
  logic [31:0] rdataQ;

  // reset for the port side, released on a clock edge
  cdm_rst_sync uRstSync (
    .core_clk(core_clk),
    .core_reset_low(core_reset_low),
    .portRstLow(portRstLow)
  );

  // bus decode
  wire busReq = cyc_i & stb_i;
  wire busWrite = busReq & we_i & ackQ;
  wire hitAddr = (adr_i == CDM_OFS_ADDR);
  wire hitWdata = (adr_i == CDM_OFS_WDATA);
  wire hitCtrl = (adr_i == CDM_OFS_CTRL);
  wire hitCmd = (adr_i == CDM_OFS_CMD);
  wire hitStatus = (adr_i == CDM_OFS_STATUS);
  wire hitRdata = (adr_i == CDM_OFS_RDATA);
  wire goPulse = busWrite & hitCmd & sel_i[0] & dat_i[CDM_CMD_GO_BIT];
  wire clrAbort = busWrite & hitStatus & sel_i[0] & dat_i[CDM_ST_ABORT_BIT];
  wire clrHalt = busWrite & hitStatus & sel_i[0] & dat_i[CDM_ST_HALT_BIT];
  wire busy = (stateQ != CDM_IDLE);

  // fields of the control register
  wire [1:0] ctrlSizeRaw = ctrlRegQ[CDM_CTRL_SIZE_LSB +: 2];
  wire [1:0] ctrlSize = (ctrlSizeRaw == CDM_SIZE_RSVD) ? CDM_SIZE_WORD : ctrlSizeRaw;
  wire ctrlDir = ctrlRegQ[CDM_CTRL_DIR_BIT];
  wire ctrlLock = ctrlRegQ[CDM_CTRL_LOCK_BIT];
  wire ctrlPriv = ctrlRegQ[CDM_CTRL_PRIV_BIT];
  wire ctrlSpec = ctrlRegQ[CDM_CTRL_SPEC_BIT];
  wire [4:0] ctrlMode = ctrlRegQ[CDM_CTRL_MODE_LSB +: 5];
  wire [3:0] ctrlBeats = ctrlRegQ[CDM_CTRL_BEATS_LSB +: 4];
  wire [3:0] beatsAfterFirst = (ctrlBeats == 4'h0) ? 4'h0 : ctrlBeats - 4'h1;
  wire startOk = goPulse & ~busy & ~haltedQ;

  // status word and read mux
  wire [31:0] statusWord = {28'h0000000, lockQ, haltedQ, abortSeenQ, busy};
  wire [31:0] readMux = hitAddr ? addrRegQ :
                        hitWdata ? wdataRegQ :
                        hitCtrl ? ctrlRegQ :
                        hitStatus ? statusWord :
                        hitRdata ? rdataQ : 32'h0000_0000;

  // wishbone slave: ack one cycle after the request, one cycle wide
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ackQ <= 1'b0;
      datOQ <= 32'h0000_0000;
    end else if (wait_state_enable) begin
      ackQ <= busReq & ~ackQ;
      datOQ <= readMux;
    end
  end

  // software registers that steer the port
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      addrRegQ <= CDM_RST_ADDR;
      wdataRegQ <= CDM_RST_WDATA;
      ctrlRegQ <= CDM_RST_CTRL;
    end else if (wait_state_enable && busWrite) begin
      if (hitAddr) begin
        addrRegQ <= byteMerge(addrRegQ, dat_i, sel_i);
      end
      if (hitWdata) begin
        wdataRegQ <= byteMerge(wdataRegQ, dat_i, sel_i);
      end
      if (hitCtrl) begin
        ctrlRegQ <= byteMerge(ctrlRegQ, dat_i, sel_i) & CDM_CTRL_MASK;
      end
    end
  end

  // sequencer next state and announce values
  always_comb begin
    stateD = stateQ;
    remD = remQ;
    curAddrD = curAddrQ;
    addrOutD = addrOutQ;
    reqLowD = reqLowQ;
    seqD = seqQ;
    moreD = moreQ;
    lockD = lockQ;
    specLowD = 1'b1;
    case (stateQ)
      CDM_IDLE: begin
        if (startOk && ctrlSpec) begin
          stateD = CDM_SPEC;
          specLowD = 1'b0;
          addrOutD = addrRegQ;
          reqLowD = 1'b1;
        end else if (startOk) begin
          stateD = CDM_ANNOUNCE;
          remD = beatsAfterFirst;
          curAddrD = addrRegQ;
          reqLowD = 1'b0;
          seqD = 1'b0;
          moreD = (beatsAfterFirst != 4'h0);
          lockD = ctrlLock;
        end
      end
      CDM_ANNOUNCE: begin
        stateD = CDM_ACCESS;
        addrOutD = curAddrQ;
        reqLowD = (remQ == 4'h0);
        seqD = (remQ != 4'h0);
        moreD = (remQ > 4'h1);
      end
      CDM_ACCESS: begin
        if (remQ != 4'h0) begin
          remD = remQ - 4'h1;
          curAddrD = curAddrQ + sizeStep(sizeQ);
          addrOutD = curAddrQ + sizeStep(sizeQ);
          reqLowD = (remQ == 4'h1);
          seqD = (remQ != 4'h1);
          moreD = (remQ > 4'h2);
        end else begin
          stateD = CDM_IDLE;
          reqLowD = 1'b1;
          seqD = 1'b0;
          moreD = 1'b0;
          lockD = 1'b0;
        end
      end
      CDM_SPEC: begin
        stateD = CDM_IDLE;
      end
      default: begin
        stateD = CDM_IDLE;
        reqLowD = 1'b1;
      end
    endcase
  end

  // port sequencer and interface outputs, all from flops
  always_ff @(posedge core_clk or negedge portRstLow) begin
    if (!portRstLow) begin
      stateQ <= CDM_IDLE;
      remQ <= 4'h0;
      curAddrQ <= 32'h0000_0000;
      addrOutQ <= 32'h0000_0000;
      reqLowQ <= 1'b1;
      seqQ <= 1'b0;
      moreQ <= 1'b0;
      lockQ <= 1'b0;
      specLowQ <= 1'b1;
    end else if (wait_state_enable) begin
      stateQ <= stateD;
      remQ <= remD;
      curAddrQ <= curAddrD;
      addrOutQ <= addrOutD;
      reqLowQ <= reqLowD;
      seqQ <= seqD;
      moreQ <= moreD;
      lockQ <= lockD;
      specLowQ <= specLowD;
    end
  end

  // per-command attributes, announced with the first request
  always_ff @(posedge core_clk or negedge portRstLow) begin
    if (!portRstLow) begin
      dirQ <= 1'b0;
      sizeQ <= CDM_SIZE_WORD;
      privQ <= 1'b0;
      modeOutQ <= CDM_RST_MODE;
      wdataOutQ <= 32'h0000_0000;
    end else if (wait_state_enable && startOk) begin
      dirQ <= ctrlDir;
      sizeQ <= ctrlSize;
      privQ <= ctrlPriv;
      modeOutQ <= ctrlMode;
      wdataOutQ <= wdataRegQ;
    end
  end

  // results of each access; a hardware set beats a software clear
  always_ff @(posedge core_clk or negedge portRstLow) begin
    if (!portRstLow) begin
      abortSeenQ <= 1'b0;
      haltedQ <= 1'b0;
      rdataQ <= 32'h0000_0000;
    end else if (wait_state_enable) begin
      if (stateQ == CDM_ACCESS && !dirQ) begin
        rdataQ <= readData;
      end
      if (stateQ == CDM_ACCESS && accessFaultInput) begin
        abortSeenQ <= 1'b1;
      end else if (clrAbort) begin
        abortSeenQ <= 1'b0;
      end
      if (stateQ == CDM_ACCESS && watchpointHaltInput) begin
        haltedQ <= 1'b1;
      end else if (clrHalt) begin
        haltedQ <= 1'b0;
      end
    end
  end

  // output wiring
  assign dat_o = datOQ;
  assign ack_o = ackQ & wait_state_enable; // a frozen cycle shows no ack, so no write is lost
  assign loadStoreAddress = addrOutQ;
  assign writeData = wdataOutQ;
  assign busLockHold = lockQ;
  assign accessSizeCode = sizeQ;
  assign burstContinueFlag = moreQ;
  assign requestLow = reqLowQ;
  assign accessModeCode = modeOutQ;
  assign directionSelect = dirQ;
  assign speculativeHintLow = specLowQ;
  assign privilegeLevelSelect = privQ;
  assign sequentialAccessFlag = seqQ;

endmodule : cdm_port

// *** verilog/cdm_pkg.sv ***
// constants and types shared by the core data memory port
package cdm_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] CDM_OFS_ADDR = 8'h00;
  localparam logic [7:0] CDM_OFS_WDATA = 8'h04;
  localparam logic [7:0] CDM_OFS_CTRL = 8'h08;
  localparam logic [7:0] CDM_OFS_CMD = 8'h0C;
  localparam logic [7:0] CDM_OFS_STATUS = 8'h10;
  localparam logic [7:0] CDM_OFS_RDATA = 8'h14;

  // control register field positions
  localparam int CDM_CTRL_SIZE_LSB = 0;
  localparam int CDM_CTRL_DIR_BIT = 2;
  localparam int CDM_CTRL_LOCK_BIT = 3;
  localparam int CDM_CTRL_PRIV_BIT = 4;
  localparam int CDM_CTRL_SPEC_BIT = 5;
  localparam int CDM_CTRL_MODE_LSB = 6;
  localparam int CDM_CTRL_BEATS_LSB = 12;
  localparam logic [31:0] CDM_CTRL_MASK = 32'h0000_F7FF;

  // command and status bit positions
  localparam int CDM_CMD_GO_BIT = 0;
  localparam int CDM_ST_BUSY_BIT = 0;
  localparam int CDM_ST_ABORT_BIT = 1;
  localparam int CDM_ST_HALT_BIT = 2;
  localparam int CDM_ST_LOCK_BIT = 3;

  // reset values
  localparam logic [31:0] CDM_RST_ADDR = 32'h0000_0000;
  localparam logic [31:0] CDM_RST_WDATA = 32'h0000_0000;
  localparam logic [31:0] CDM_RST_CTRL = 32'h0000_1002;
  localparam logic [4:0] CDM_RST_MODE = 5'h13;

  // access size codes
  localparam logic [1:0] CDM_SIZE_BYTE = 2'h0;
  localparam logic [1:0] CDM_SIZE_HALF = 2'h1;
  localparam logic [1:0] CDM_SIZE_WORD = 2'h2;
  localparam logic [1:0] CDM_SIZE_RSVD = 2'h3;

  // port sequencer states
  typedef enum logic [1:0] {
    CDM_IDLE = 2'b00,
    CDM_ANNOUNCE = 2'b01,
    CDM_ACCESS = 2'b10,
    CDM_SPEC = 2'b11
  } cdm_state_t;

endpackage : cdm_pkg

// *** verilog/cdm_rst_sync.sv ***
// reset synchroniser: asynchronous assertion, clocked release
`timescale 1ns/10ps
module cdm_rst_sync (
  // clock and asynchronous reset pin
  input wire logic core_clk,
  input wire logic core_reset_low,
  // reset for the port logic
  output logic portRstLow
);

  logic stage1Q;
  logic stage2Q;

  // two flops release the reset on a clock edge
  always_ff @(posedge core_clk or negedge core_reset_low) begin
    if (!core_reset_low) begin
      stage1Q <= 1'b0;
      stage2Q <= 1'b0;
    end else begin
      stage1Q <= 1'b1;
      stage2Q <= stage1Q;
    end
  end

  assign portRstLow = stage2Q;

endmodule : cdm_rst_sync

// *** bench/cdm_port_monitor.sv ***
// pin-level assertions for the data memory port
`timescale 1ns/10ps
module cdm_port_monitor
  import cdm_pkg::*;
(
  // clock, resets, stall
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic core_reset_low,
  input wire logic wait_state_enable,
  // register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // memory side
  input wire logic [31:0] loadStoreAddress,
  input wire logic [31:0] writeData,
  input wire logic busLockHold,
  input wire logic [1:0] accessSizeCode,
  input wire logic burstContinueFlag,
  input wire logic requestLow,
  input wire logic [4:0] accessModeCode,
  input wire logic directionSelect,
  input wire logic speculativeHintLow,
  input wire logic sequentialAccessFlag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!core_reset_low || !nrst);
  // relations between port outputs and their causes
  property p_spec;
    !(!speculativeHintLow && !requestLow);
  endproperty
  a_spec: assert property (p_spec) else $error("hint with request");
  property p_size;
    accessSizeCode != CDM_SIZE_RSVD;
  endproperty
  a_size: assert property (p_size) else $error("reserved size code");
  property p_more;
    burstContinueFlag && wait_state_enable |=> sequentialAccessFlag;
  endproperty
  a_more: assert property (p_more) else $error("burst not followed");
  property p_seq;
    sequentialAccessFlag |-> !requestLow;
  endproperty
  a_seq: assert property (p_seq) else $error("sequential without access");
  property p_step;
    sequentialAccessFlag && wait_state_enable |=>
      loadStoreAddress == $past(loadStoreAddress) + (32'h1 << $past(accessSizeCode));
  endproperty
  a_step: assert property (p_step) else $error("address step wrong");
  property p_lock;
    $fell(busLockHold) |-> requestLow && $past(requestLow);
  endproperty
  a_lock: assert property (p_lock) else $error("lock dropped early");
  property p_dir;
    !requestLow && wait_state_enable |=> $stable(directionSelect);
  endproperty
  a_dir: assert property (p_dir) else $error("direction changed");
  property p_mode;
    !requestLow && wait_state_enable |=> $stable(accessModeCode);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed");
  property p_wdata;
    !requestLow && directionSelect && wait_state_enable |=> $stable(writeData);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data changed");
  property p_ack;
    cyc_i && stb_i && !ack_o && wait_state_enable |=> ack_o || !wait_state_enable;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
  property p_stall;
    !wait_state_enable |=> $stable(requestLow) && $stable(loadStoreAddress);
  endproperty
  a_stall: assert property (p_stall) else $error("moved in stall");
endmodule : cdm_port_monitor

bind cdm_port cdm_port_monitor mon_u (.core_clk, .nrst, .core_reset_low,
  .wait_state_enable, .cyc_i, .stb_i, .ack_o, .loadStoreAddress, .writeData,
  .busLockHold, .accessSizeCode, .burstContinueFlag, .requestLow, .accessModeCode,
  .directionSelect, .speculativeHintLow, .sequentialAccessFlag);

// *** bench/cdm_mem_model.sv ***
// memory system model serving the data accesses of the port
`timescale 1ns/10ps
module cdm_mem_model (
  // clock, reset, stall
  input wire logic core_clk,
  input wire logic core_reset_low,
  input wire logic wait_state_enable,
  // port side
  input wire logic [31:0] loadStoreAddress,
  input wire logic [31:0] writeData,
  input wire logic requestLow,
  input wire logic directionSelect,
  input wire logic speculativeHintLow,
  output logic [31:0] readData,
  output logic accessFaultInput,
  output logic [31:0] lastWrite
);
  logic accQ, specQ;
  wire logic [31:0] pat = loadStoreAddress ^ 32'h5A5A_A5A5;
  // mark access and hint cycles, keep the last stored word; one master only
  always_ff @(posedge core_clk) begin
    if (!core_reset_low) begin
      accQ <= 1'b0;
      specQ <= 1'b0;
      lastWrite <= 32'h0000_0000;
    end else if (wait_state_enable) begin
      accQ <= !requestLow;
      specQ <= !speculativeHintLow;
      if (accQ && directionSelect) lastWrite <= writeData;
    end
  end
  // data only in access cycles, inverted pattern otherwise
  assign readData = accQ ? pat : ~pat;
  // top page forbidden, speculation always refused
  assign accessFaultInput = (accQ && loadStoreAddress[31:28] == 4'hF) || specQ;
endmodule : cdm_mem_model

// *** bench/tb.sv ***
// self-checking bench for the data memory port
`timescale 1ns/10ps
module tb;
  import cdm_pkg::*;
  logic core_clk = 0, nrst = 0, core_reset_low = 0, wait_state_enable = 1;
  logic cyc_i = 0, stb_i = 0, we_i = 0, watchpointHaltInput = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, loadStoreAddress, writeData, readData, lastWrite;
  logic ack_o, accessFaultInput, busLockHold, burstContinueFlag, requestLow;
  logic directionSelect, speculativeHintLow, privilegeLevelSelect, sequentialAccessFlag;
  logic [1:0] accessSizeCode;
  logic [4:0] accessModeCode, seenMode;
  logic [31:0] seenSpec, q;
  logic seenLock, seenPriv;
  logic [1:0] seenSize;
  int n_errors = 0, comparisons = 0, nAcc = 0, nSeq = 0, nMore = 0;
  cdm_port dut_u (.core_clk, .nrst, .core_reset_low, .wait_state_enable, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .loadStoreAddress,
    .writeData, .readData, .accessFaultInput, .watchpointHaltInput, .busLockHold,
    .accessSizeCode, .burstContinueFlag, .requestLow, .accessModeCode,
    .directionSelect, .speculativeHintLow, .privilegeLevelSelect, .sequentialAccessFlag);
  cdm_mem_model mem_u (.core_clk, .core_reset_low, .wait_state_enable,
    .loadStoreAddress, .writeData, .requestLow, .directionSelect,
    .speculativeHintLow, .readData, .accessFaultInput, .lastWrite);
  // clock
  initial forever #25 core_clk = ~core_clk;
  // tally announced accesses and note side signals
  always @(posedge core_clk) begin
    if (!requestLow && wait_state_enable) begin
      nAcc++;
      seenPriv = privilegeLevelSelect;
      seenMode = accessModeCode;
      seenSize = accessSizeCode;
    end
    if (sequentialAccessFlag && wait_state_enable) nSeq++;
    if (burstContinueFlag && wait_state_enable) nMore++;
    if (busLockHold) seenLock = 1;
    if (!speculativeHintLow) seenSpec = loadStoreAddress;
  end
  task automatic final_report();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (ack_o !== 1'b1 && i < 60);
    if (i >= 60) begin
      n_errors++;
      final_report();
    end
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge core_clk);
  endtask : wb
  function automatic logic [31:0] ctl(input int sz, dr, lk, pv, sp, md, bt);
    return 32'(sz | dr << 2 | lk << 3 | pv << 4 | sp << 5 | md << 6 | bt << 12);
  endfunction : ctl
  // start a command and poll until not busy
  task automatic run(input logic [31:0] a, input logic [31:0] c);
    int i;
    wb(1, CDM_OFS_ADDR, a);
    wb(1, CDM_OFS_CTRL, c);
    nAcc = 0;
    nSeq = 0;
    nMore = 0;
    seenLock = 0;
    wb(1, CDM_OFS_CMD, 32'h1);
    i = 0;
    do begin
      wb(0, CDM_OFS_STATUS, 0);
      i++;
    end while (q[0] !== 1'b0 && i < 40);
    if (i >= 40) begin
      n_errors++;
      final_report();
    end
  endtask : run
  task automatic s_regs();
    check({requestLow, speculativeHintLow, accessModeCode}, {2'b11, CDM_RST_MODE});
    wb(0, CDM_OFS_CTRL, 0);
    check(q, CDM_RST_CTRL);
    wb(0, 8'h20, 0);
    check(q, 32'h0);
    wb(1, CDM_OFS_CTRL, 32'hFFFF_FFFF);
    wb(0, CDM_OFS_CTRL, 0);
    check(q, CDM_CTRL_MASK);
  endtask : s_regs
  task automatic s_sizes();
    for (int s = 0; s < 3; s++) begin
      run(32'h100, ctl(s, 0, 0, 0, 0, 5'h10, 2));
      check(nAcc, 2);
      check(seenSize, s);
      wb(0, CDM_OFS_RDATA, 0);
      check(q, (32'h100 + (1 << s)) ^ 32'h5A5A_A5A5);
    end
  endtask : s_sizes
  task automatic s_write_lock();
    wb(1, CDM_OFS_WDATA, 32'hC0DE_1234);
    run(32'h200, ctl(2, 1, 1, 1, 0, 5'h1F, 3));
    check(lastWrite, 32'hC0DE_1234);
    check(seenLock, 1);
    check({nSeq[3:0], nMore[3:0]}, {4'h2, 4'h2});
    check({seenPriv, seenMode, nAcc[3:0]}, {1'b1, 5'h1F, 4'h3});
  endtask : s_write_lock
  task automatic s_fault_watch();
    run(32'hF000_0000, ctl(2, 0, 0, 0, 0, 0, 1));
    check(q & 32'h2, 32'h2);
    wb(1, CDM_OFS_STATUS, 32'h2);
    watchpointHaltInput <= 1;
    run(32'h300, ctl(2, 0, 0, 0, 0, 0, 1));
    watchpointHaltInput <= 0;
    check(q & 32'h6, 32'h4);
    run(32'h300, ctl(2, 0, 0, 0, 0, 0, 1));
    check(nAcc, 0);
    wb(1, CDM_OFS_STATUS, 32'h4);
  endtask : s_fault_watch
  task automatic s_spec();
    run(32'h340, ctl(2, 0, 0, 0, 1, 0, 1));
    check(seenSpec, 32'h340);
  endtask : s_spec
  task automatic s_stall();
    fork
      run(32'h400, ctl(1, 0, 0, 0, 0, 0, 4));
      repeat (30) begin
        @(posedge core_clk);
        wait_state_enable <= 0;
        @(posedge core_clk);
        wait_state_enable <= 1;
      end
    join
    check(nAcc, 4);
    wb(0, CDM_OFS_RDATA, 0);
    check(q, 32'h406 ^ 32'h5A5A_A5A5);
  endtask : s_stall
  // reset, then every scenario in turn
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1;
    core_reset_low <= 1;
    repeat (3) @(posedge core_clk);
    s_regs();
    s_sizes();
    s_write_lock();
    s_fault_watch();
    s_spec();
    s_stall();
    final_report();
  end
endmodule : tb
